/* rtl/brt_pkg.sv */
// package for the bit error-rate tester: map, fields, resets, counts
package brt_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PCFG = 8'h04;
    localparam logic [7:0] ADDR_SEED_LO = 8'h08;
    localparam logic [7:0] ADDR_SEED_HI = 8'h0C;
    localparam logic [7:0] ADDR_CMD = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    localparam logic [7:0] ADDR_BCNT = 8'h18;
    localparam logic [7:0] ADDR_ECNT = 8'h1C;
    // tester_control_reg fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_TXINV = 1;
    localparam int CTRL_RXINV = 2;
    localparam int CTRL_NORESYNC = 3;
    localparam int CTRL_ERRSRC = 4;
    localparam int CTRL_RATE_LSB = 8;
    // pattern_config_reg fields
    localparam int PCFG_LEN_LSB = 0;
    localparam int PCFG_REP = 5;
    localparam int PCFG_QRSS = 6;
    localparam int PCFG_TAP_LSB = 8;
    // tester_command_reg fields
    localparam int CMD_TXLOAD = 0;
    localparam int CMD_RXLOAD = 1;
    localparam int CMD_UPD = 2;
    localparam int CMD_ERRINS = 3;
    // reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] PCFG_RST = 16'h0000;
    localparam logic [15:0] SEED_RST = 16'hFFFF;
    localparam logic [3:0] CMD_RST = 4'h0;
    // counts
    localparam logic [5:0] SYNC_BITS_LAST = 6'h1F;
    localparam logic [5:0] WIN_LAST = 6'h3F;
    localparam logic [2:0] WIN_ERR_LIMIT = 3'h6;
    // last count of the error-rate divider for n = 0..7, 0 = rate off
    localparam logic [23:0] RATE_LAST [8] = '{24'h000000, 24'h000009,
        24'h000063, 24'h0003E7, 24'h00270F, 24'h01869F, 24'h0F423F,
        24'h98967F};
    localparam int QRSS_TAP_A = 17;
    localparam int QRSS_TAP_B = 20;
    localparam int QRSS_ZERO_RUN = 14;
    localparam int ERR_W = 24;
    localparam int BIT_W = 32;
    typedef enum logic [1:0] {
        RX_LOAD,
        RX_SEARCH,
        RX_VERIFY,
        RX_SYNC
    } brt_rx_state_type;
endpackage : brt_pkg

/* rtl/brt_top.sv */
// bit error-rate tester: pattern generator, checker, apb registers
`timescale 1ns/1ps
module brt_top
    import brt_pkg::*;
(
    input logic ref_clk,
    input logic rst,
    input logic clk_en,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input logic tx_bit_req,
    output logic tx_data,
    output logic tx_data_valid,
    input logic rx_bit_valid,
    input logic rx_bit_in,
    input logic manual_error_insert_in
);
    // apb and register state
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [15:0] ctrl_r, ctrl_nxt;
    logic [15:0] pcfg_r, pcfg_nxt;
    logic [15:0] seed_lo_r, seed_lo_nxt;
    logic [15:0] seed_hi_r, seed_hi_nxt;
    logic [3:0] cmd_r, cmd_nxt;
    logic [3:0] cmd_d_r;
    logic mei_s1_r, mei_s2_r, mei_s3_r;
    // transmit state
    logic [31:0] tx_gen_r, tx_gen_nxt;
    logic tx_data_r, tx_data_nxt;
    logic tx_valid_r, tx_valid_nxt;
    logic [23:0] rate_cnt_r, rate_cnt_nxt;
    logic err_pend_r, err_pend_nxt;
    // receive state
    brt_rx_state_type rx_st_r, rx_st_nxt;
    logic [31:0] rx_gen_r, rx_gen_nxt;
    logic [5:0] phase_r, phase_nxt;
    logic [5:0] win_r, win_nxt;
    logic [2:0] werr_r, werr_nxt;
    logic [BIT_W-1:0] bit_cnt_r, bit_cnt_nxt;
    logic [ERR_W-1:0] err_cnt_r, err_cnt_nxt;
    logic [BIT_W-1:0] bcnt_reg_r, bcnt_reg_nxt;
    logic [ERR_W-1:0] ecnt_reg_r, ecnt_reg_nxt;
    logic err_present_r, err_present_nxt;
    logic sync_lost_r, sync_lost_nxt;

    logic tester_en, rep_mode, qrss_mode;
    logic [4:0] len_f, tap_f;
    logic [2:0] rate_n;
    logic [31:0] seed_mask, seed_val;
    logic tx_load, rx_load, upd, sw_err, pin_err, err_req;
    logic tx_out, tx_fb, rx_out, rx_fb, rx_b, mis;
    logic wr_fire;

    assign tester_en = ctrl_r[CTRL_EN];
    assign rep_mode = pcfg_r[PCFG_REP];
    assign qrss_mode = pcfg_r[PCFG_QRSS] & ~rep_mode;
    assign len_f = pcfg_r[PCFG_LEN_LSB +: 5];
    assign tap_f = pcfg_r[PCFG_TAP_LSB +: 5];
    assign rate_n = ctrl_r[CTRL_RATE_LSB +: 3];
    // mask keeps n = length + 1 low bits of the seed
    assign seed_mask = 32'hFFFFFFFF >> (5'd31 - len_f);
    assign seed_val = {seed_hi_r, seed_lo_r} & seed_mask;
    assign tx_load = cmd_r[CMD_TXLOAD] & ~cmd_d_r[CMD_TXLOAD];
    assign rx_load = cmd_r[CMD_RXLOAD] & ~cmd_d_r[CMD_RXLOAD];
    assign upd = cmd_r[CMD_UPD] & ~cmd_d_r[CMD_UPD];
    assign sw_err = cmd_r[CMD_ERRINS] & ~cmd_d_r[CMD_ERRINS];
    assign pin_err = mei_s2_r & ~mei_s3_r;
    assign err_req = ctrl_r[CTRL_ERRSRC] ? pin_err : sw_err;
    assign wr_fire = psel & penable & pready_r & pwrite;

    // returns {output, feedback}; stage k sits at index k-1
    function automatic logic [1:0] gen_step(
        input logic [31:0] s,
        input logic [4:0] ni,
        input logic [4:0] yi,
        input logic rep,
        input logic qrss
    );
        logic f;
        logic o;
        if (rep) begin
            f = s[ni];
        end else if (qrss) begin
            f = s[QRSS_TAP_A-1] ^ s[QRSS_TAP_B-1];
        end else begin
            f = s[ni] ^ s[yi];
        end
        if (!rep && s[30:0] == 31'h0) begin
            f = 1'b1;
        end
        o = f;
        if (qrss && s[QRSS_ZERO_RUN-1:0] == 14'h0) begin
            o = 1'b1;
        end
        return {o, f};
    endfunction : gen_step

    assign {tx_out, tx_fb} = gen_step(tx_gen_r, len_f, tap_f, rep_mode,
        qrss_mode);
    assign {rx_out, rx_fb} = gen_step(rx_gen_r, len_f, tap_f, rep_mode,
        qrss_mode);
    assign rx_b = rx_bit_in ^ ctrl_r[CTRL_RXINV];
    assign mis = rx_b ^ rx_out;

    // apb slave, one wait-free access cycle
    always_comb begin
        prdata_nxt = 32'h00000000;
        pready_nxt = psel & ~penable;
        pslverr_nxt = 1'b0;
        ctrl_nxt = ctrl_r;
        pcfg_nxt = pcfg_r;
        seed_lo_nxt = seed_lo_r;
        seed_hi_nxt = seed_hi_r;
        cmd_nxt = cmd_r;
        if (psel && !penable) begin
            unique case (paddr)
                ADDR_CTRL: prdata_nxt = {16'h0000, ctrl_r};
                ADDR_PCFG: prdata_nxt = {16'h0000, pcfg_r};
                ADDR_SEED_LO: prdata_nxt = {16'h0000, seed_lo_r};
                ADDR_SEED_HI: prdata_nxt = {16'h0000, seed_hi_r};
                ADDR_CMD: prdata_nxt = {28'h0000000, cmd_r};
                ADDR_STAT: prdata_nxt = {30'h00000000, sync_lost_r,
                    err_present_r};
                ADDR_BCNT: prdata_nxt = bcnt_reg_r;
                ADDR_ECNT: prdata_nxt = {8'h00, ecnt_reg_r};
                default: pslverr_nxt = 1'b1;
            endcase
        end
        if (wr_fire) begin
            unique case (paddr)
                ADDR_CTRL: ctrl_nxt = pwdata[15:0];
                ADDR_PCFG: pcfg_nxt = pwdata[15:0];
                ADDR_SEED_LO: seed_lo_nxt = pwdata[15:0];
                ADDR_SEED_HI: seed_hi_nxt = pwdata[15:0];
                ADDR_CMD: cmd_nxt = pwdata[3:0];
                default: cmd_nxt = cmd_r;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            ctrl_r <= CTRL_RST;
            pcfg_r <= PCFG_RST;
            seed_lo_r <= SEED_RST;
            seed_hi_r <= SEED_RST;
            cmd_r <= CMD_RST;
            cmd_d_r <= CMD_RST;
            mei_s1_r <= 1'b0;
            mei_s2_r <= 1'b0;
            mei_s3_r <= 1'b0;
        end else if (clk_en) begin
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            ctrl_r <= ctrl_nxt;
            pcfg_r <= pcfg_nxt;
            seed_lo_r <= seed_lo_nxt;
            seed_hi_r <= seed_hi_nxt;
            cmd_r <= cmd_nxt;
            cmd_d_r <= cmd_r;
            mei_s1_r <= manual_error_insert_in;
            mei_s2_r <= mei_s1_r;
            mei_s3_r <= mei_s2_r;
        end
    end

    // transmit generator and error insertion
    always_comb begin
        tx_gen_nxt = tx_gen_r;
        tx_data_nxt = tx_data_r;
        tx_valid_nxt = 1'b0;
        rate_cnt_nxt = rate_cnt_r;
        err_pend_nxt = err_pend_r;
        if (tx_load) begin
            tx_gen_nxt = seed_val;
            rate_cnt_nxt = 24'h000000;
        end else if (tester_en && tx_bit_req) begin
            tx_gen_nxt = {tx_gen_r[30:0], tx_fb};
            tx_valid_nxt = 1'b1;
            if (rate_n == 3'h0 || rate_cnt_r == RATE_LAST[rate_n]) begin
                rate_cnt_nxt = 24'h000000;
            end else begin
                rate_cnt_nxt = rate_cnt_r + 24'h000001;
            end
            tx_data_nxt = tx_out ^ err_pend_r ^ ctrl_r[CTRL_TXINV]
                ^ (rate_n != 3'h0 && rate_cnt_r == RATE_LAST[rate_n]);
            err_pend_nxt = 1'b0;
        end
        if (err_req) begin
            err_pend_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_gen_r <= 32'h00000000;
            tx_data_r <= 1'b0;
            tx_valid_r <= 1'b0;
            rate_cnt_r <= 24'h000000;
            err_pend_r <= 1'b0;
        end else if (clk_en) begin
            tx_gen_r <= tx_gen_nxt;
            tx_data_r <= tx_data_nxt;
            tx_valid_r <= tx_valid_nxt;
            rate_cnt_r <= rate_cnt_nxt;
            err_pend_r <= err_pend_nxt;
        end
    end

    // receive synchroniser and counters
    always_comb begin
        logic inc_b;
        logic inc_e;
        logic [2:0] werr_add;
        inc_b = 1'b0;
        inc_e = 1'b0;
        werr_add = werr_r;
        rx_st_nxt = rx_st_r;
        rx_gen_nxt = rx_gen_r;
        phase_nxt = phase_r;
        win_nxt = win_r;
        werr_nxt = werr_r;
        if (rx_load) begin
            rx_st_nxt = rep_mode ? RX_SEARCH : RX_LOAD;
            rx_gen_nxt = rep_mode ? seed_val : 32'h00000000;
            phase_nxt = 6'h00;
        end else if (tester_en && rx_bit_valid) begin
            unique case (rx_st_r)
                RX_LOAD: begin
                    rx_gen_nxt = {rx_gen_r[30:0], rx_b};
                    phase_nxt = phase_r + 6'h01;
                    if (phase_r == SYNC_BITS_LAST) begin
                        rx_st_nxt = RX_VERIFY;
                        phase_nxt = 6'h00;
                    end
                end
                RX_SEARCH: begin
                    // hold the generator on a miss to slip one position
                    if (!mis) begin
                        rx_gen_nxt = {rx_gen_r[30:0], rx_fb};
                        rx_st_nxt = RX_VERIFY;
                        phase_nxt = 6'h00;
                    end
                end
                RX_VERIFY: begin
                    rx_gen_nxt = {rx_gen_r[30:0], rx_fb};
                    phase_nxt = phase_r + 6'h01;
                    if (mis) begin
                        rx_st_nxt = rep_mode ? RX_SEARCH : RX_LOAD;
                        phase_nxt = 6'h00;
                    end else if (phase_r == SYNC_BITS_LAST) begin
                        rx_st_nxt = RX_SYNC;
                        win_nxt = 6'h00;
                        werr_nxt = 3'h0;
                    end
                end
                RX_SYNC: begin
                    rx_gen_nxt = {rx_gen_r[30:0], rx_fb};
                    inc_b = 1'b1;
                    inc_e = mis;
                    win_nxt = win_r + 6'h01;
                    if (mis && werr_r != 3'h7) begin
                        werr_add = werr_r + 3'h1;
                    end
                    werr_nxt = (win_r == WIN_LAST) ? 3'h0 : werr_add;
                    if (werr_add >= WIN_ERR_LIMIT
                        && !ctrl_r[CTRL_NORESYNC]) begin
                        rx_st_nxt = rep_mode ? RX_SEARCH : RX_LOAD;
                        phase_nxt = 6'h00;
                    end
                end
            endcase
        end
        bcnt_reg_nxt = upd ? bit_cnt_r : bcnt_reg_r;
        ecnt_reg_nxt = upd ? err_cnt_r : ecnt_reg_r;
        bit_cnt_nxt = (upd ? '0 : bit_cnt_r) + {31'h0, inc_b};
        err_cnt_nxt = (upd ? '0 : err_cnt_r) + {23'h0, inc_e};
        err_present_nxt = (err_cnt_nxt != '0);
        sync_lost_nxt = (rx_st_nxt != RX_SYNC);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_st_r <= RX_LOAD;
            rx_gen_r <= 32'h00000000;
            phase_r <= 6'h00;
            win_r <= 6'h00;
            werr_r <= 3'h0;
            bit_cnt_r <= '0;
            err_cnt_r <= '0;
            bcnt_reg_r <= '0;
            ecnt_reg_r <= '0;
            err_present_r <= 1'b0;
            sync_lost_r <= 1'b1;
        end else if (clk_en) begin
            rx_st_r <= rx_st_nxt;
            rx_gen_r <= rx_gen_nxt;
            phase_r <= phase_nxt;
            win_r <= win_nxt;
            werr_r <= werr_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            err_cnt_r <= err_cnt_nxt;
            bcnt_reg_r <= bcnt_reg_nxt;
            ecnt_reg_r <= ecnt_reg_nxt;
            err_present_r <= err_present_nxt;
            sync_lost_r <= sync_lost_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign tx_data = tx_data_r;
    assign tx_data_valid = tx_valid_r;

    default clocking cb @(posedge ref_clk iff clk_en);
    endclocking
    default disable iff (rst);

    sequence s_rx_bit;
        tester_en && rx_bit_valid && !rx_load;
    endsequence
    sequence s_verify_miss;
        s_rx_bit ##0 rx_st_r == RX_VERIFY && mis;
    endsequence

    property p_err_flag;
        (err_cnt_r != '0) && !upd |=> err_present_r;
    endproperty
    a_err_flag: assert property (p_err_flag)
        else $error("error flag low with nonzero count");

    property p_oos;
        rx_load |=> sync_lost_r ##1 sync_lost_r;
    endproperty
    a_oos: assert property (p_oos)
        else $error("sync lost flag not shown after load");

    property p_hold;
        (rx_st_r != RX_SYNC) && !upd |=> $stable(bit_cnt_r)
            && $stable(err_cnt_r);
    endproperty
    a_hold: assert property (p_hold)
        else $error("counters moved while out of sync");

    property p_count;
        s_rx_bit ##0 rx_st_r == RX_SYNC && !upd |=>
            bit_cnt_r == $past(bit_cnt_r) + 32'h1
            && err_cnt_r == $past(err_cnt_r) + {23'h0, $past(mis)};
    endproperty
    a_count: assert property (p_count)
        else $error("bit or error count step wrong");

    property p_update;
        upd |=> bcnt_reg_r == $past(bit_cnt_r)
            && ecnt_reg_r == $past(err_cnt_r) && bit_cnt_r <= 32'h1;
    endproperty
    a_update: assert property (p_update)
        else $error("monitor update did not copy and clear");

    property p_seed;
        tx_load |=> tx_gen_r == $past(seed_val);
    endproperty
    a_seed: assert property (p_seed)
        else $error("transmit generator not preset with seed");

    property p_shift;
        tester_en && tx_bit_req && !tx_load |=>
            tx_gen_r[31:1] == $past(tx_gen_r[30:0]) && tx_data_valid;
    endproperty
    a_shift: assert property (p_shift)
        else $error("transmit generator did not shift");

    property p_lockup;
        tester_en && tx_bit_req && !tx_load && !rep_mode
            && tx_gen_r[30:0] == 31'h0 |=> tx_gen_r[0];
    endproperty
    a_lockup: assert property (p_lockup)
        else $error("all-zero generator not forced to one");

    property p_verify;
        s_verify_miss |=> rx_st_r != RX_SYNC && sync_lost_r;
    endproperty
    a_verify: assert property (p_verify)
        else $error("verify accepted a mismatching bit");

    property p_resync;
        s_rx_bit ##0 rx_st_r == RX_SYNC && mis && werr_r == 3'h5
            && win_r != WIN_LAST && !ctrl_r[CTRL_NORESYNC]
            |=> rx_st_r != RX_SYNC;
    endproperty
    a_resync: assert property (p_resync)
        else $error("sixth window error did not restart sync");
endmodule : brt_top

/* verification/brt_line_model.sv */
// line-side partner: requests test bits and loops them back as payload
`timescale 1ns/1ps
module brt_line_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic slow,
    input wire logic tx_data,
    input wire logic tx_data_valid,
    output logic tx_bit_req,
    output logic rx_bit_valid,
    output logic rx_bit_in
);
    logic [1:0] gap_r;

    // slow mode asks for one slot in three
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gap_r <= 2'h0;
            tx_bit_req <= 1'b0;
            rx_bit_valid <= 1'b0;
            rx_bit_in <= 1'b0;
        end else begin
            gap_r <= (gap_r == 2'h2) ? 2'h0 : gap_r + 2'h1;
            tx_bit_req <= run && (!slow || gap_r == 2'h0);
            rx_bit_valid <= tx_data_valid;
            // outside a payload slot the data line does not hold its value
            rx_bit_in <= tx_data_valid ? tx_data : ~rx_bit_in;
        end
    end
endmodule : brt_line_model

/* verification/bit_error_rate_tester_tb.sv */
// self-checking bench for the bit error-rate tester
`timescale 1ns/1ps
`define CHK(act, exp) \
    begin \
        num_checks++; \
        if ((act) !== (exp)) begin \
            error_cnt++; \
            $display("BAD t=%0t got=%h exp=%h", $time, act, exp); \
        end \
    end
module bit_error_rate_tester_tb;
    import brt_pkg::*;
    logic ref_clk, rst, clk_en, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, tx_bit_req, tx_data, tx_data_valid;
    logic rx_bit_valid, rx_bit_in, manual_error_insert_in, run, slow;
    int error_cnt = 0;
    int num_checks = 0;
    int rx_cnt = 0;
    logic txq[$];
    logic [15:0] t_pc [4] = '{16'h0021, 16'h0037, 16'h0253, 16'h080A};
    // the all-zero seed of the last pattern exercises the lock-up guard
    logic [31:0] t_sd [4] = '{32'hFFFFFFFE, 32'hFF200022, 32'hFFFFFFFF,
        32'h00000000};
    logic [7:0] r_ad [8] = '{ADDR_CTRL, ADDR_PCFG, ADDR_SEED_LO,
        ADDR_SEED_HI, ADDR_CMD, ADDR_STAT, ADDR_BCNT, ADDR_ECNT};
    logic [31:0] r_rv [8] = '{32'h0, 32'h0, 32'hFFFF, 32'hFFFF, 32'h0,
        32'h2, 32'h0, 32'h0};

    brt_top dut_u (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_bit_req(tx_bit_req), .tx_data(tx_data),
        .tx_data_valid(tx_data_valid), .rx_bit_valid(rx_bit_valid),
        .rx_bit_in(rx_bit_in),
        .manual_error_insert_in(manual_error_insert_in));

    brt_line_model line_u (.ref_clk(ref_clk), .rst(rst), .run(run),
        .slow(slow), .tx_data(tx_data), .tx_data_valid(tx_data_valid),
        .tx_bit_req(tx_bit_req), .rx_bit_valid(rx_bit_valid),
        .rx_bit_in(rx_bit_in));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (tx_data_valid === 1'b1) txq.push_back(tx_data);
        if (rx_bit_valid === 1'b1) rx_cnt++;
    end

    task automatic print_verdict;
        if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict

    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic er);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the slave's answer
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        q = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic er;
        apb(1'b1, a, d, q, er);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
        input logic ee = 1'b0);
        logic [31:0] q;
        logic er;
        apb(1'b0, a, 32'h0, q, er);
        `CHK(q, e)
        `CHK(er, ee)
    endtask : rd_chk

    // command bits act on a rising stored bit, so clear first
    task automatic cmd(input logic [3:0] c);
        wr(ADDR_CMD, 32'h0);
        wr(ADDR_CMD, {28'h0, c});
    endtask : cmd

    task automatic go(input int n);
        run <= 1'b1;
        repeat (n) @(posedge ref_clk);
        run <= 1'b0;
        repeat (10) @(posedge ref_clk);
    endtask : go

    function automatic logic ref_bit(inout logic [31:0] s, input int n,
        input int y, input logic rep, input logic q);
        logic fb;
        logic o;
        if (q) fb = s[QRSS_TAP_A - 1] ^ s[QRSS_TAP_B - 1];
        else if (rep) fb = s[n - 1];
        else fb = s[n - 1] ^ s[y - 1];
        if (!rep && s[30:0] == 31'h0) fb = 1'b1;
        o = fb | (q && s[QRSS_ZERO_RUN - 1:0] == 14'h0);
        s = {s[30:0], fb};
        return o;
    endfunction : ref_bit

    task automatic stream(input logic [15:0] pc, input logic [31:0] sd,
        input logic inv);
        logic [31:0] s;
        logic b;
        s = sd;
        run <= 1'b0;
        slow <= inv;
        wr(ADDR_CTRL, {29'h0, inv, inv, 1'b1});
        wr(ADDR_PCFG, {16'h0, pc});
        rd_chk(ADDR_PCFG, {16'h0, pc});
        wr(ADDR_SEED_LO, {16'h0, sd[15:0]});
        wr(ADDR_SEED_HI, {16'h0, sd[31:16]});
        cmd(4'h3);
        txq.delete();
        go(400);
        for (int i = 0; i < 40; i++) begin
            b = ref_bit(s, int'(pc[4:0]) + 1, int'(pc[12:8]) + 1,
                pc[PCFG_REP], pc[PCFG_QRSS]);
            `CHK(txq[i], b ^ inv)
        end
        rd_chk(ADDR_STAT, 32'h0);
    endtask : stream

    initial begin
        repeat (40000) @(posedge ref_clk);
        error_cnt++;
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        manual_error_insert_in = 1'b0;
        run = 1'b0;
        slow = 1'b0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 8; i++) rd_chk(r_ad[i], r_rv[i]);
        rd_chk(8'h20, 32'h0, 1'b1);
        wr(ADDR_STAT, 32'hFFFF);
        rd_chk(ADDR_STAT, 32'h2);
        go(20);
        `CHK(txq.size(), 0)
        for (int i = 0; i < 4; i++) stream(t_pc[i], t_sd[i], i == 1);
        cmd(4'h4);
        rx_cnt = 0;
        cmd(4'h8);
        go(50);
        wr(ADDR_CTRL, 32'h11);
        manual_error_insert_in <= 1'b1;
        repeat (8) @(posedge ref_clk);
        manual_error_insert_in <= 1'b0;
        go(200);
        rd_chk(ADDR_STAT, 32'h1);
        cmd(4'h4);
        rd_chk(ADDR_BCNT, 32'(rx_cnt));
        rd_chk(ADDR_ECNT, 32'h2);
        rd_chk(ADDR_STAT, 32'h0);
        wr(ADDR_CTRL, 32'h109);
        go(300);
        rd_chk(ADDR_STAT, 32'h1);
        wr(ADDR_CTRL, 32'h101);
        go(200);
        rd_chk(ADDR_STAT, 32'h3);
        cmd(4'h4);
        go(200);
        cmd(4'h4);
        rd_chk(ADDR_BCNT, 32'h0);
        rd_chk(ADDR_ECNT, 32'h0);
        wr(ADDR_CTRL, 32'h1);
        go(300);
        rd_chk(ADDR_STAT, 32'h0);
        print_verdict();
    end
endmodule : bit_error_rate_tester_tb
